// ### rtl/touch_report_pkg.sv
// constants and types shared by the touch report register block
package touch_report_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_GESTURE = 8'h01;
  localparam logic [7:0] REG_COUNT = 8'h02;
  localparam logic [7:0] POINT_BASE = 8'h03;
  localparam logic [7:0] POINT_STRIDE = 8'h06;
  localparam logic [7:0] POINT_LAST_XH = 8'h39;
  localparam int POINT_NUM = 10;

  // byte position inside one point group
  localparam logic [2:0] OFS_XH = 3'h0;
  localparam logic [2:0] OFS_XL = 3'h1;
  localparam logic [2:0] OFS_YH = 3'h2;
  localparam logic [2:0] OFS_YL = 3'h3;

  // ==========================================================
  // field layout
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 6;
  localparam logic [2:0] MODE_WORK = 3'h0;
  localparam logic [2:0] MODE_FACTORY = 3'h4;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [3:0] COUNT_MIN = 4'h1;
  localparam logic [3:0] COUNT_MAX = 4'h5;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam logic [1:0] EVT_PUT_DOWN = 2'h0;
  localparam logic [1:0] EVT_LIFTED = 2'h1;
  localparam logic [1:0] EVT_CONTACT = 2'h2;
  localparam logic [1:0] EVT_RESERVED = 2'h3;

  // gesture codes
  localparam logic [7:0] GEST_NONE = 8'h00;
  localparam logic [7:0] GEST_UP = 8'h10;
  localparam logic [7:0] GEST_DOWN = 8'h14;
  localparam logic [7:0] GEST_RIGHT = 8'h18;
  localparam logic [7:0] GEST_ZOOM_IN = 8'h48;
  localparam logic [7:0] GEST_ZOOM_OUT = 8'h49;

  // point word: xh, xl, yh, yl from msb down
  localparam int WORD_W = 32;
  localparam int IDX_W = 4;

  // ==========================================================
  // timing
  localparam int CLK_KHZ = 25000;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_MIN_CYC = (CLK_KHZ + SCL_MAX_KHZ - 1) / SCL_MAX_KHZ;

  // ==========================================================
  // serial link states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } link_state_e;

endpackage

// ### rtl/point_mem_if.sv
// write and read ports of the point report memory
`timescale 1ns/1ps
interface point_mem_if;
  import touch_report_pkg::*;
  logic we;
  logic [IDX_W-1:0] waddr;
  logic [WORD_W-1:0] wdata;
  logic [IDX_W-1:0] raddr;
  logic [WORD_W-1:0] rdata;
  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### rtl/link_pin_sync.sv
// two-flop synchronisers and bus condition detection for the serial pins
`timescale 1ns/1ps
module link_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  logic [1:0] scl_meta_q;
  logic [1:0] sda_meta_q;
  logic scl_s_q;
  logic sda_s_q;
  logic scl_prev_q;
  logic sda_prev_q;

  // ==========================================================
  // synchronisers, idle bus is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_q <= 2'h3;
      sda_meta_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (ce) begin
      scl_meta_q <= {scl_meta_q[0], scl_in};
      sda_meta_q <= {sda_meta_q[0], sda_in};
      scl_prev_q <= scl_meta_q[1];
      sda_prev_q <= sda_meta_q[1];
    end
  end

  assign scl_s_q = scl_prev_q;
  assign sda_s_q = sda_prev_q;
  assign sda_s = sda_s_q;
  // edges compare second stage against the stage after it
  assign scl_rise = ce & scl_meta_q[1] & ~scl_s_q;
  assign scl_fall = ce & ~scl_meta_q[1] & scl_s_q;
  assign start_seen = ce & scl_meta_q[1] & scl_s_q & ~sda_meta_q[1] & sda_s_q;
  assign stop_seen = ce & scl_meta_q[1] & scl_s_q & sda_meta_q[1] & ~sda_s_q;
endmodule

// ### rtl/point_mem.sv
// report memory, one word per touch point, registered read
`timescale 1ns/1ps
module point_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  point_mem_if.mem port
);
  import touch_report_pkg::*;

  logic [WORD_W-1:0] store_q [POINT_NUM];
  logic [WORD_W-1:0] rdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < POINT_NUM; i++) begin
        store_q[i] <= '0;
      end
    end else if (ce && port.we && int'(port.waddr) < POINT_NUM) begin
      store_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= (int'(port.raddr) < POINT_NUM) ? store_q[port.raddr] : '0;
    end
  end

  assign port.rdata = rdata_q;

  a_mem_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    ce && port.we && port.waddr == port.raddr && int'(port.waddr) < POINT_NUM ##1 ce && $stable(port.raddr)
    |=> rdata_q == $past(port.wdata, 2)) else $error("point word not read back");
endmodule

// ### rtl/touch_report_regs.sv
// touch report register block reached over the two-wire serial link
// ==========================================================
`timescale 1ns/1ps
module touch_report_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pt_wr,
  input wire logic [touch_report_pkg::IDX_W-1:0] pt_index,
  input wire logic [1:0] pt_event,
  input wire logic [11:0] pt_x,
  input wire logic [11:0] pt_y,
  input wire logic [3:0] pt_tag,
  input wire logic frame_wr,
  input wire logic [7:0] frame_gesture,
  input wire logic [3:0] frame_count,
  output logic [2:0] op_mode,
  output logic factory_mode
);
  import touch_report_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic legal_gesture(input logic [7:0] g);
    return g == GEST_NONE || g == GEST_UP || g == GEST_DOWN || g == GEST_RIGHT ||
           g == GEST_ZOOM_IN || g == GEST_ZOOM_OUT;
  endfunction

  // point index and byte slot for a register address
  function automatic logic [7:0] point_rel(input logic [7:0] a);
    return a - POINT_BASE;
  endfunction

  function automatic logic [IDX_W-1:0] point_idx(input logic [7:0] a);
    logic [7:0] q;
    q = point_rel(a) / POINT_STRIDE;
    return q[IDX_W-1:0];
  endfunction

  function automatic logic [2:0] point_slot(input logic [7:0] a);
    logic [7:0] r;
    r = point_rel(a) % POINT_STRIDE;
    return r[2:0];
  endfunction

  // ==========================================================
  // pins and memory
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  link_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  point_mem_if mem_if ();

  point_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .port(mem_if.mem)
  );

  // ==========================================================
  // report capture from the sensing logic
  logic [7:0] gest_q;
  logic [3:0] count_q;

  assign mem_if.we = ce & pt_wr;
  assign mem_if.waddr = pt_index;
  assign mem_if.wdata = {pt_event, 2'h0, pt_x[11:8],
                         pt_x[7:0],
                         pt_tag, pt_y[11:8],
                         pt_y[7:0]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gest_q <= GEST_NONE;
      count_q <= COUNT_RESET;
    end else if (ce && frame_wr) begin
      // unknown codes never reach the host
      gest_q <= legal_gesture(frame_gesture) ? frame_gesture : GEST_NONE;
      // saturate so the host never sees a count above COUNT_MAX
      count_q <= (frame_count > COUNT_MAX) ? COUNT_MAX : frame_count;
    end
  end

  // ==========================================================
  // link state machine
  link_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic nack_q;
  logic [2:0] mode_q;
  logic oe_q;
  logic [7:0] rd_byte;
  logic byte_done;

  // only the ten point groups reach the memory, higher pointers must not alias back onto point 0
  assign mem_if.raddr = (ptr_q >= POINT_BASE && point_rel(ptr_q) < 8'(POINT_NUM) * POINT_STRIDE) ?
                        point_idx(ptr_q) : '1;

  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == REG_MODE) begin
      rd_byte[MODE_MSB:MODE_LSB] = mode_q;
    end else if (ptr_q == REG_GESTURE) begin
      rd_byte = gest_q;
    end else if (ptr_q == REG_COUNT) begin
      rd_byte = {4'h0, count_q};
    end else begin
      // gap bytes and addresses past the tenth group read zero
      unique case (point_slot(ptr_q))
        OFS_XH: rd_byte = mem_if.rdata[31:24];
        OFS_XL: rd_byte = mem_if.rdata[23:16];
        OFS_YH: rd_byte = mem_if.rdata[15:8];
        OFS_YL: rd_byte = mem_if.rdata[7:0];
        default: rd_byte = 8'h00;
      endcase
    end
  end

  assign byte_done = scl_fall && ((state_q == ST_RDATA && bit_cnt_q == 4'h7) ||
                     (state_q == ST_WDATA && bit_cnt_q == 4'h8));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b1;
    end else if (ce) begin
      if (start_seen) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
      end else if (stop_seen) begin
        state_q <= ST_IDLE;
      end else if (scl_rise) begin
        if (state_q == ST_ADDR || state_q == ST_REG || state_q == ST_WDATA) begin
          shift_q <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        if (state_q == ST_RDATA_ACK) begin
          nack_q <= sda_s;
        end
      end else if (scl_fall) begin
        unique case (state_q)
          ST_IDLE: state_q <= ST_IDLE;
          ST_ADDR: begin
            if (bit_cnt_q == 4'h8) begin
              state_q <= (shift_q[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
              rw_q <= shift_q[0];
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              state_q <= ST_RDATA;
              tx_q <= rd_byte;
            end else begin
              state_q <= ST_REG;
            end
          end
          ST_REG: begin
            if (bit_cnt_q == 4'h8) begin
              state_q <= ST_REG_ACK;
            end
          end
          ST_REG_ACK, ST_WDATA_ACK: begin
            state_q <= ST_WDATA;
            bit_cnt_q <= 4'h0;
          end
          ST_WDATA: begin
            if (bit_cnt_q == 4'h8) begin
              state_q <= ST_WDATA_ACK;
            end
          end
          ST_RDATA: begin
            if (bit_cnt_q == 4'h7) begin
              state_q <= ST_RDATA_ACK;
            end else begin
              tx_q <= {tx_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          ST_RDATA_ACK: begin
            bit_cnt_q <= 4'h0;
            if (nack_q) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_RDATA;
              tx_q <= rd_byte;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // register pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= REG_MODE;
    end else if (ce) begin
      if (scl_fall && state_q == ST_REG && bit_cnt_q == 4'h8) begin
        ptr_q <= shift_q;
      end else if (byte_done) begin
        // advanced long before the next load, so the memory read has settled
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // mode register, writes to read-only bytes are acked and dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RESET;
    end else if (ce && byte_done && state_q == ST_WDATA && ptr_q == REG_MODE) begin
      mode_q <= shift_q[MODE_MSB:MODE_LSB];
    end
  end

  assign op_mode = mode_q;
  assign factory_mode = (mode_q == MODE_FACTORY);

  // ==========================================================
  // open-drain data pin, changes only while the clock line is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else if (ce) begin
      oe_q <= state_q == ST_ADDR_ACK || state_q == ST_REG_ACK || state_q == ST_WDATA_ACK ||
              (state_q == ST_RDATA && !tx_q[7]);
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // ==========================================================
  // checks
  a_mode_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    ce && byte_done && state_q == ST_WDATA && ptr_q == REG_MODE
    |=> mode_q == $past(shift_q[MODE_MSB:MODE_LSB]) && ptr_q == 8'h01)
    else $error("mode write not taken");

  a_factory_entry: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(factory_mode) |-> $past(ce && byte_done && state_q == ST_WDATA && ptr_q == REG_MODE))
    else $error("factory mode entered without a mode write");

  a_gesture_legal: assert property (@(posedge clk) disable iff (!rst_n)
    ce && frame_wr && !legal_gesture(frame_gesture) |=> gest_q == GEST_NONE)
    else $error("illegal gesture code stored");

  a_count_range: assert property (@(posedge clk) disable iff (!rst_n)
    ce && frame_wr && frame_count >= COUNT_MIN |=> count_q >= COUNT_MIN && count_q <= COUNT_MAX)
    else $error("touch count out of range");

  a_event_field: assert property (@(posedge clk) disable iff (!rst_n)
    mem_if.we |-> mem_if.wdata[31:30] == pt_event && mem_if.wdata[29:28] == 2'h0)
    else $error("event flag or reserved bits misplaced");

  a_coord_pack: assert property (@(posedge clk) disable iff (!rst_n)
    mem_if.we |-> {mem_if.wdata[27:24], mem_if.wdata[23:16]} == pt_x &&
    {mem_if.wdata[11:8], mem_if.wdata[7:0]} == pt_y && mem_if.wdata[15:12] == pt_tag)
    else $error("coordinate or tag packing wrong");

  a_ptr_advance: assert property (@(posedge clk) disable iff (!rst_n)
    ce && byte_done |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance");

  a_addr_ack_drive: assert property (@(posedge clk) disable iff (!rst_n)
    ce && state_q == ST_ADDR_ACK ##1 ce |-> sda_oe)
    else $error("address not acknowledged");

  a_last_group_read: assert property (@(posedge clk) disable iff (!rst_n)
    ptr_q == POINT_LAST_XH |-> mem_if.raddr == 4'h9 && point_slot(ptr_q) == OFS_XH)
    else $error("tenth point group misdecoded");

  a_ack_release: assert property (@(posedge clk) disable iff (!rst_n)
    ce && scl_fall && state_q == ST_REG_ACK ##1 ce |=> !sda_oe)
    else $error("ack held past its bit");
endmodule

// ### verif/touch_link_host.sv
// serial link host model that addresses and reads the touch report registers
`timescale 1ns/1ps
module touch_link_host #(
  parameter logic [6:0] DEV = 7'h2a,  // arbitrary value
  parameter int QTR = 16,
  parameter int HOLD = 120
) (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ==========================================================
  // bus conditions and bits
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // serial clock period of 64 clk stays just under 400 kHz
  task automatic start_cond();
    sda_low = 1'b0;
    tick(QTR);
    scl = 1'b1;
    tick(HOLD);
    sda_low = 1'b1;
    tick(HOLD);
    scl = 1'b0;
    tick(QTR);
  endtask

  task automatic stop_cond();
    sda_low = 1'b1;
    tick(QTR);
    scl = 1'b1;
    tick(HOLD);
    sda_low = 1'b0;
    tick(HOLD);
  endtask

  task automatic bit_out(input logic b);
    sda_low = ~b;
    tick(QTR);
    scl = 1'b1;
    tick(2 * QTR);
    scl = 1'b0;
    tick(QTR);
  endtask

  // data line released, pull-up decides unless the device pulls low
  task automatic bit_in(output logic b);
    sda_low = 1'b0;
    tick(QTR);
    scl = 1'b1;
    tick(QTR);
    b = sda;
    tick(QTR);
    scl = 1'b0;
    tick(QTR);
  endtask

  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(v[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask

  task automatic byte_in(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_in(v[i]);
    end
    bit_out(last);
  endtask

  // ==========================================================
  // transfers: register address, optional data byte, then a read burst
  task automatic access(input logic [7:0] ra, input logic wr, input logic [7:0] wd, input int nr,
                        output logic [7:0] rd [$], output logic ok);
    logic a;
    logic [7:0] v;
    ok = 1'b1;
    rd.delete();
    start_cond();
    byte_out({DEV, 1'b0}, a);
    ok &= a;
    byte_out(ra, a);
    ok &= a;
    if (wr) begin
      byte_out(wd, a);
      ok &= a;
    end
    if (nr > 0) begin
      start_cond();
      byte_out({DEV, 1'b1}, a);
      ok &= a;
      for (int i = 0; i < nr; i++) begin
        byte_in(v, i == nr - 1);
        rd.push_back(v);
      end
    end
    stop_cond();
  endtask

  task automatic probe(input logic [6:0] a7, output logic ack);
    start_cond();
    byte_out({a7, 1'b0}, ack);
    stop_cond();
  endtask
endmodule

// ### verif/touch_report_regs_tb.sv
// self-checking bench for the touch report register block
`timescale 1ns/1ps
module touch_report_regs_tb;
  import touch_report_pkg::*;
  localparam logic [6:0] DEV = 7'h2a;  // arbitrary value
  logic clk, rst_n, ce, scl, host_low, sda_wire, sda_out, sda_oe, pt_wr, frame_wr, factory_mode, ok;
  logic [IDX_W-1:0] pt_index;
  logic [1:0] pt_event;
  logic [11:0] pt_x, pt_y;
  logic [3:0] pt_tag, frame_count, sh_cnt;
  logic [7:0] frame_gesture, sh_gest, mv;
  logic [2:0] op_mode, sh_mode;
  logic [1:0] sh_evt [POINT_NUM];
  logic [11:0] sh_x [POINT_NUM];
  logic [11:0] sh_y [POINT_NUM];
  logic [3:0] sh_tag [POINT_NUM];
  logic [7:0] rd [$];
  logic [31:0] r;
  int fails, samples_checked, seed;

  // open drain with pull-up
  assign sda_wire = ~(host_low | (sda_oe & ~sda_out));

  touch_report_regs #(.DEV_ADDR(DEV)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .pt_wr(pt_wr), .pt_index(pt_index), .pt_event(pt_event), .pt_x(pt_x),
    .pt_y(pt_y), .pt_tag(pt_tag), .frame_wr(frame_wr), .frame_gesture(frame_gesture),
    .frame_count(frame_count), .op_mode(op_mode), .factory_mode(factory_mode));

  touch_link_host #(.DEV(DEV)) i_host (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda_wire));

  // ==========================================================
  // expectations
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    int k;
    int o;
    k = (int'(a) - 3) / 6;
    o = (int'(a) - 3) % 6;
    if (a == REG_MODE) return {1'b0, sh_mode, 4'h0};
    if (a == REG_GESTURE) return sh_gest;
    if (a == REG_COUNT) return {4'h0, sh_cnt};
    if (a < POINT_BASE || k >= POINT_NUM) return 8'h00;
    case (o)
      0: return {sh_evt[k], 2'b00, sh_x[k][11:8]};
      1: return sh_x[k][7:0];
      2: return {sh_tag[k], sh_y[k][11:8]};
      3: return sh_y[k][7:0];
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] exp_gest(input logic [7:0] g);
    case (g)
      GEST_UP, GEST_DOWN, GEST_RIGHT, GEST_ZOOM_IN, GEST_ZOOM_OUT: return g;
      default: return GEST_NONE;
    endcase
  endfunction

  task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", name, e, g);
      fails++;
    end
  endtask

  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (98000) @(posedge clk);
    fails++;
    complete_run();
  end

  initial begin : main
    logic [7:0] gtab [7];
    logic [7:0] mtab [7];
    logic ack;
    gtab = '{GEST_UP, GEST_DOWN, GEST_RIGHT, GEST_ZOOM_IN, GEST_ZOOM_OUT, GEST_NONE, 8'h11};
    mtab = '{8'h40, 8'h00, 8'hff, 8'h0f, 8'hc5, 8'h30, 8'h00};
    seed = 65734;
    {rst_n, pt_wr, frame_wr, pt_index, pt_event, pt_x, pt_y, pt_tag, frame_gesture, frame_count} = '0;
    ce = 1'b1;
    {sh_gest, sh_cnt, sh_mode} = '0;
    for (int n = 0; n < POINT_NUM; n++) begin
      {sh_evt[n], sh_x[n], sh_y[n], sh_tag[n]} = '0;
    end
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    i_host.access(REG_MODE, 1'b0, 8'h00, 3, rd, ok);
    check("ack", 8'h01, {7'h0, ok});
    for (int a = 0; a < 3; a++) check($sformatf("reg_%0h", a), exp_reg(a[7:0]), rd[a]);
    // mode written, pointer moves on to gesture and count in the same transfer
    for (int i = 0; i < 7; i++) begin
      r = $random(seed);
      mtab[6] = r[23:16];
      @(posedge clk);
      #1 frame_wr = 1'b1;
      frame_gesture = gtab[i];
      frame_count = (i < 2) ? COUNT_MAX + 4'(i) : r[3:0];
      @(posedge clk);
      #1 frame_wr = 1'b0;
      sh_gest = exp_gest(frame_gesture);
      sh_cnt = (frame_count > COUNT_MAX) ? COUNT_MAX : frame_count;
      mv = mtab[i];
      sh_mode = mv[MODE_MSB:MODE_LSB];
      i_host.access(REG_MODE, 1'b1, mv, 2, rd, ok);
      check("ack", 8'h01, {7'h0, ok});
      check("gesture", sh_gest, rd[0]);
      check("count", {4'h0, sh_cnt}, rd[1]);
      check("op_mode", {5'h0, sh_mode}, {5'h0, op_mode});
      check("factory_mode", {7'h0, sh_mode == MODE_FACTORY}, {7'h0, factory_mode});
    end
    // frame strobe while ce is low must leave the stored count alone
    @(posedge clk);
    #1 ce = 1'b0;
    frame_wr = 1'b1;
    frame_count = sh_cnt ^ 4'h1;
    @(posedge clk);
    #1 ce = 1'b1;
    frame_wr = 1'b0;
    // write to a read-only byte is acked and dropped
    i_host.access(REG_GESTURE, 1'b1, 8'h5a, 1, rd, ok);
    check("count", {4'h0, sh_cnt}, rd[0]);
    i_host.probe(DEV ^ 7'h01, ack);
    check("foreign_ack", 8'h00, {7'h0, ack});
    // back to back point stores, slot 10 must be ignored
    for (int n = 0; n <= POINT_NUM; n++) begin
      r = $random(seed);
      @(posedge clk);
      #1 pt_wr = 1'b1;
      pt_index = IDX_W'(n);
      pt_event = (r[29:28] == EVT_RESERVED) ? EVT_CONTACT : r[29:28];
      pt_x = r[11:0];
      pt_y = r[23:12];
      pt_tag = r[27:24];
      if (n == 0) {pt_event, pt_x, pt_y} = {EVT_PUT_DOWN, 24'h0};
      if (n == POINT_NUM - 1) {pt_event, pt_x, pt_y, pt_tag} = {EVT_LIFTED, 28'hfffffff};
      if (n < POINT_NUM) {sh_evt[n], sh_x[n], sh_y[n], sh_tag[n]} = {pt_event, pt_x, pt_y, pt_tag};
    end
    @(posedge clk);
    #1 pt_wr = 1'b0;
    i_host.access(REG_MODE, 1'b0, 8'h00, 64, rd, ok);
    check("ack", 8'h01, {7'h0, ok});
    for (int a = 0; a < 64; a++) check($sformatf("reg_%0h", a), exp_reg(a[7:0]), rd[a]);
    complete_run();
  end
endmodule
